// ===== rtl/pisc_pkg.sv
package pisc_pkg;

	// ------------------------------------------------------------
	// Controller register map
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL    = 4'h0; // Bus control, bit 0 is the address bit.
	localparam logic [3:0] REG_WRDATA  = 4'h1; // Write data, then issues a device write.
	localparam logic [3:0] REG_RDCMD   = 4'h2; // Issues a device read.
	localparam logic [3:0] REG_ACKCMD  = 4'h3; // Issues an acknowledge sequence.
	localparam logic [3:0] REG_STATUS  = 4'h4; // Busy, poll pending.
	localparam logic [3:0] REG_RDDATA  = 4'h5; // Last data read from the device.
	localparam logic [3:0] REG_VECTOR  = 4'h6; // Vector bytes of last acknowledge.
	localparam logic [3:0] REG_BUFEN   = 4'h7; // Seen buffer-enable and cascade value.

	// ------------------------------------------------------------
	// Command word fields
	// ------------------------------------------------------------
	localparam int THIRD_OPERATION_WORD_RIS_BIT  = 0; // Status select.
	localparam int THIRD_OPERATION_WORD_RR_BIT   = 1; // Status read enable.
	localparam int THIRD_OPERATION_WORD_P_BIT    = 2; // Poll.
	localparam int THIRD_OPERATION_WORD_ID_BIT   = 3; // Marks a third operation word.
	localparam int FIRST_INIT_WORD_TRIGGER_SELECT_BIT_BIT = 3; // Trigger select.
	localparam int FOURTH_INIT_WORD_BUF_BIT  = 3; // Buffered mode.
	localparam int FOURTH_INIT_WORD_MS_BIT   = 2; // Master in buffered mode.
	localparam int CTRL_A0_BIT   = 0;
	localparam int CTRL_WIDE_BIT = 1; // Two vector byte format when set; three bytes when clear.

	// ------------------------------------------------------------
	// Strobe timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 250;
	localparam int STROBE_NS     = 160; // Least read, write and acknowledge pulse width.
	localparam int SETUP_NS      = 10;  // Least address setup before a strobe.
	localparam int STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
	localparam logic [7:0] SETUP_CNT  = 8'(SETUP_CYC);

	typedef enum logic [2:0] {
		PISC_IDLE,
		PISC_SETUP,
		PISC_PULSE,
		PISC_GAP
	} pisc_state_t;

endpackage

// ===== rtl/pisc_host.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module pisc_host #(
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [3:0]    addr,
	input  wire logic [31:0]   wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic [31:0]        rdata,
	output logic               dev_rd_n,
	output logic               dev_wr_n,
	output logic               dev_ack_n,
	output logic               dev_a0,
	output logic [DW-1:0]      dev_d_out,
	output logic               dev_d_oe,
	input  wire logic [DW-1:0] dev_d_in,
	input  wire logic          dev_buf_en_n,
	input  wire logic [2:0]    dev_cascade
);

	// ------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PISC_K_WR,
		PISC_K_RD,
		PISC_K_ACK
	} pisc_kind_t;

	pisc_pkg::pisc_state_t state;
	pisc_pkg::pisc_state_t next_state;
	pisc_kind_t            kind;
	pisc_kind_t            next_kind;
	logic [7:0]            cnt;
	logic [7:0]            next_cnt;
	logic [1:0]            pulse_left;
	logic [1:0]            next_pulse_left;
	logic [1:0]            byte_idx;
	logic [1:0]            next_byte_idx;
	logic                  a0;
	logic                  next_a0;
	logic                  one_byte;
	logic                  next_one_byte;
	logic [DW-1:0]         wbyte;
	logic [DW-1:0]         next_wbyte;
	logic [DW-1:0]         rbyte;
	logic [DW-1:0]         next_rbyte;
	logic [23:0]           vec;
	logic [23:0]           next_vec;
	logic                  poll_pend;
	logic                  next_poll_pend;
	logic                  buf_seen;
	logic                  next_buf_seen;
	logic [2:0]            cas_seen;
	logic [2:0]            next_cas_seen;
	logic                  rd_n;
	logic                  wr_n;
	logic                  ack_n;
	logic                  d_oe;
	logic                  next_rd_n;
	logic                  next_wr_n;
	logic                  next_ack_n;
	logic                  next_d_oe;
	logic [31:0]           next_rdata;
	logic                  busy;

	assign busy      = (state != pisc_pkg::PISC_IDLE);
	assign dev_rd_n  = rd_n;
	assign dev_wr_n  = wr_n;
	assign dev_ack_n = ack_n;
	assign dev_a0    = a0;
	assign dev_d_out = wbyte;
	assign dev_d_oe  = d_oe;

	// Next values. Orders arriving while busy are dropped; software polls busy first.
	always_comb
	begin
		next_state      = state;
		next_kind       = kind;
		next_cnt        = cnt;
		next_pulse_left = pulse_left;
		next_byte_idx   = byte_idx;
		next_a0         = a0;
		next_one_byte   = one_byte;
		next_wbyte      = wbyte;
		next_rbyte      = rbyte;
		next_vec        = vec;
		next_poll_pend  = poll_pend;
		next_buf_seen   = buf_seen;
		next_cas_seen   = cas_seen;
		next_rd_n       = rd_n;
		next_wr_n       = wr_n;
		next_ack_n      = ack_n;
		next_d_oe       = d_oe;
		next_rdata      = 32'h0000_0000;
		if (wr && !busy)
		begin
			unique case (addr)
				pisc_pkg::REG_CTRL:
				begin
					next_a0       = wdata[pisc_pkg::CTRL_A0_BIT];
					next_one_byte = wdata[pisc_pkg::CTRL_WIDE_BIT];
				end
				pisc_pkg::REG_WRDATA:
				begin
					// Command words go out unchanged; software orders selects and end-of-service.
					next_wbyte = wdata[DW-1:0];
					next_kind  = PISC_K_WR;
					next_state = pisc_pkg::PISC_SETUP;
					next_cnt   = pisc_pkg::SETUP_CNT;
					// A third operation word with poll set arms a poll; it overrides status read.
					if (!wdata[7] && !a0 && wdata[pisc_pkg::THIRD_OPERATION_WORD_ID_BIT] && !wdata[4])
						next_poll_pend = wdata[pisc_pkg::THIRD_OPERATION_WORD_P_BIT];
				end
				pisc_pkg::REG_RDCMD:
				begin
					next_kind  = PISC_K_RD;
					next_state = pisc_pkg::PISC_SETUP;
					next_cnt   = pisc_pkg::SETUP_CNT;
				end
				pisc_pkg::REG_ACKCMD:
				begin
					next_kind       = PISC_K_ACK;
					next_state      = pisc_pkg::PISC_SETUP;
					next_cnt        = pisc_pkg::SETUP_CNT;
					next_pulse_left = one_byte ? 2'h1 : 2'h2;
					next_byte_idx   = 2'h0;
					next_vec        = 24'h00_0000;
				end
				default:
				begin
				end
			endcase
		end
		unique case (state)
			pisc_pkg::PISC_IDLE:
			begin
			end
			pisc_pkg::PISC_SETUP:
			begin
				if (cnt <= 8'h01)
				begin
					next_state = pisc_pkg::PISC_PULSE;
					next_cnt   = pisc_pkg::STROBE_CNT;
					next_rd_n  = (kind != PISC_K_RD);
					next_wr_n  = (kind != PISC_K_WR);
					next_ack_n = (kind != PISC_K_ACK);
					next_d_oe  = (kind == PISC_K_WR);
				end
				else
					next_cnt = cnt - 8'h01;
			end
			pisc_pkg::PISC_PULSE:
			begin
				if (cnt <= 8'h01)
				begin
					next_rd_n  = 1'b1;
					next_wr_n  = 1'b1;
					next_ack_n = 1'b1;
					next_d_oe  = 1'b0;
					next_state = pisc_pkg::PISC_GAP;
					next_cnt   = pisc_pkg::STROBE_CNT;
					// Data and cascade are captured on the trailing edge of the strobe.
					if (kind == PISC_K_RD)
					begin
						next_rbyte     = dev_d_in;
						next_poll_pend = 1'b0;
					end
					if (kind == PISC_K_ACK)
					begin
						next_vec[8*byte_idx +: 8] = dev_d_in;
						next_byte_idx  = byte_idx + 2'h1;
						next_cas_seen  = dev_cascade;
					end
					if (kind != PISC_K_WR)
						next_buf_seen = !dev_buf_en_n;
				end
				else
					next_cnt = cnt - 8'h01;
			end
			default:
			begin
				if (cnt <= 8'h01)
				begin
					if (kind == PISC_K_ACK && pulse_left != 2'h0)
					begin
						next_pulse_left = pulse_left - 2'h1;
						next_state      = pisc_pkg::PISC_PULSE;
						next_cnt        = pisc_pkg::STROBE_CNT;
						next_ack_n      = 1'b0;
					end
					else
						next_state = pisc_pkg::PISC_IDLE;
				end
				else
					next_cnt = cnt - 8'h01;
			end
		endcase
		if (rd)
		begin
			unique case (addr)
				pisc_pkg::REG_STATUS: next_rdata = {30'h0, poll_pend, busy};
				pisc_pkg::REG_RDDATA: next_rdata = {24'h00_0000, rbyte};
				pisc_pkg::REG_VECTOR: next_rdata = {8'h00, vec};
				pisc_pkg::REG_BUFEN:  next_rdata = {28'h000_0000, cas_seen, buf_seen};
				pisc_pkg::REG_CTRL:   next_rdata = {30'h0, one_byte, a0};
				default:              next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Registers only; strobes rest high after reset.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state      <= pisc_pkg::PISC_IDLE;
			kind       <= PISC_K_WR;
			cnt        <= 8'h00;
			pulse_left <= 2'h0;
			byte_idx   <= 2'h0;
			a0         <= 1'b0;
			one_byte   <= 1'b0;
			wbyte      <= '0;
			rbyte      <= '0;
			vec        <= 24'h00_0000;
			poll_pend  <= 1'b0;
			buf_seen   <= 1'b0;
			cas_seen   <= 3'h0;
			rd_n       <= 1'b1;
			wr_n       <= 1'b1;
			ack_n      <= 1'b1;
			d_oe       <= 1'b0;
			rdata      <= 32'h0000_0000;
		end
		else
		begin
			state      <= next_state;
			kind       <= next_kind;
			cnt        <= next_cnt;
			pulse_left <= next_pulse_left;
			byte_idx   <= next_byte_idx;
			a0         <= next_a0;
			one_byte   <= next_one_byte;
			wbyte      <= next_wbyte;
			rbyte      <= next_rbyte;
			vec        <= next_vec;
			poll_pend  <= next_poll_pend;
			buf_seen   <= next_buf_seen;
			cas_seen   <= next_cas_seen;
			rd_n       <= next_rd_n;
			wr_n       <= next_wr_n;
			ack_n      <= next_ack_n;
			d_oe       <= next_d_oe;
			rdata      <= next_rdata;
		end
	end

endmodule

// ===== verification/pisc_monitor.sv
`timescale 1ns/1ps
module pisc_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        dev_rd_n,
	input wire logic        dev_wr_n,
	input wire logic        dev_ack_n,
	input wire logic        dev_a0,
	input wire logic [7:0]  dev_d_out,
	input wire logic        dev_d_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic strb;
	// Any strobe low means the device is being addressed.
	assign strb = !dev_rd_n || !dev_wr_n || !dev_ack_n;
	one_strobe_a: assert property ($onehot0({!dev_rd_n, !dev_wr_n, !dev_ack_n}))
		else $error("two strobes low");
	wr_width_a: assert property ($fell(dev_wr_n) |-> ##39 !dev_wr_n ##1 dev_wr_n)
		else $error("write pulse width");
	rd_width_a: assert property ($fell(dev_rd_n) |-> ##39 !dev_rd_n ##1 dev_rd_n)
		else $error("read pulse width");
	ack_width_a: assert property ($fell(dev_ack_n) |-> ##39 !dev_ack_n ##1 dev_ack_n)
		else $error("acknowledge pulse width");
	strobe_gap_a: assert property ($fell(strb) |=> !strb [*8])
		else $error("strobes too close");
	addr_hold_a: assert property (strb |-> $stable(dev_a0))
		else $error("address bit moved in strobe");
	wdata_hold_a: assert property (!dev_wr_n |-> $stable(dev_d_out) && dev_d_oe)
		else $error("write data moved or undriven");
	bus_free_a: assert property ((!dev_rd_n || !dev_ack_n) |-> !dev_d_oe)
		else $error("host drives during device read");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside its cycle");
	cover property ($fell(dev_wr_n));
	cover property ($fell(dev_rd_n));
	cover property ($fell(dev_ack_n));
endmodule
bind pisc_host pisc_monitor mon_u (.clk(clk), .rst_n(rst_n), .rd(rd), .rdata(rdata),
	.dev_rd_n(dev_rd_n), .dev_wr_n(dev_wr_n), .dev_ack_n(dev_ack_n), .dev_a0(dev_a0),
	.dev_d_out(dev_d_out), .dev_d_oe(dev_d_oe));

// ===== verification/pisc_dev.sv
`timescale 1ns/1ps
// Device model with no slaves, so the cascade lines stay low; the init word sets the trigger mode.
module pisc_dev (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] irq,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       ack_n,
	input  wire logic       a0,
	input  wire logic [7:0] din,
	output logic [7:0]      dout,
	output logic            buf_en_n,
	output logic [2:0]      cascade
);
	logic [7:0] pending_request_reg, in_service_reg, request_mask_reg, prev, last, pend;
	logic [2:0] pr, lvl, vl;
	logic [1:0] nack;
	logic       sel, poll, drive, trigger_select_bit;
	// Highest unmasked request, or the default level when none remains.
	assign pend = pending_request_reg & ~request_mask_reg;
	always_comb
	begin
		lvl = 3'h7;
		for (int i = 7; i >= 0; i--)
			if (pend[i])
				lvl = 3'(i);
	end
	// A released bus toggles every cycle so stale data is never mistaken for a read.
	assign drive = !rd_n || !ack_n;
	assign dout = !drive ? ~last : !ack_n ? {5'h00, vl} :
		a0 ? request_mask_reg : poll ? {|pend, 4'h0, lvl} : sel ? in_service_reg : pending_request_reg;
	assign buf_en_n = !drive;
	assign cascade = 3'h0;
	// Strobe edges are found by sampling the strobes at each clock.
	always @(posedge clk)
	begin
		prev <= irq;
		pr <= {rd_n, wr_n, ack_n};
		last <= dout;
		if (!rst_n)
			{pending_request_reg, in_service_reg, request_mask_reg, sel, poll, nack, trigger_select_bit} <= '0;
		else
		begin
			// A level request follows its pin; an edge request is lost if its pin falls early.
			pending_request_reg <= trigger_select_bit ? irq : ((pending_request_reg | (irq & ~prev)) & irq);
			if (!pr[1] && wr_n && a0)
				request_mask_reg <= din;
			else if (!pr[1] && wr_n && din[3] && !din[4])
			begin
				poll <= din[2];
				if (din[1] && !din[2])
					sel <= din[0];
			end
			else if (!pr[1] && wr_n && din[5] && !din[4])
				in_service_reg <= in_service_reg & (in_service_reg - 8'h01);
			// An initialization word sets the trigger mode and reselects the pending register.
			else if (!pr[1] && wr_n && din[4])
			begin
				trigger_select_bit <= din[3];
				sel  <= 1'b0;
			end
			if (!pr[2] && rd_n)
				poll <= 1'b0;
			if (pr[0] && !ack_n)
				nack <= (nack == 2'h2) ? 2'h0 : nack + 2'h1;
			if ((pr[0] && !ack_n && nack == 2'h0) || (!pr[2] && rd_n && poll))
			begin
				vl <= lvl;
				if (|pend)
				begin
					in_service_reg[lvl] <= 1'b1;
					pending_request_reg[lvl] <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [7:0]  irq = 8'h00;
	logic [31:0] rdata, v;
	logic [7:0]  d_out, d_in;
	logic [2:0]  cas;
	logic        rd_n, wr_n, ack_n, a0, oe, ben_n;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	always #2 clk = ~clk;
	pisc_host dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .dev_rd_n(rd_n), .dev_wr_n(wr_n), .dev_ack_n(ack_n), .dev_a0(a0),
		.dev_d_out(d_out), .dev_d_oe(oe), .dev_d_in(d_in), .dev_buf_en_n(ben_n),
		.dev_cascade(cas));
	pisc_dev dev_u (.clk(clk), .rst_n(rst_n), .irq(irq), .rd_n(rd_n), .wr_n(wr_n),
		.ack_n(ack_n), .a0(a0), .din(d_out), .dout(d_in), .buf_en_n(ben_n), .cascade(cas));
	// A hang is cut short well beyond the few thousand cycles the run needs.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			end_sim;
		end
	end
	task end_sim;
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task bw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task br(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Busy is polled with a bound so a stuck transfer still ends the run.
	task idle;
		int n;
		logic [31:0] s;
		n = 0;
		s = 32'h1;
		while (s[0] !== 1'b0 && n < 300)
		begin
			br(pisc_pkg::REG_STATUS, s);
			n++;
		end
		if (s[0] !== 1'b0)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: transfer never finished", $time);
		end
	endtask
	task dw(input logic a, input logic [7:0] d);
		bw(pisc_pkg::REG_CTRL, {31'h0, a});
		bw(pisc_pkg::REG_WRDATA, {24'h0, d});
		idle;
	endtask
	task dr(input logic a, input logic [7:0] exp);
		bw(pisc_pkg::REG_CTRL, {31'h0, a});
		bw(pisc_pkg::REG_RDCMD, 32'h0);
		idle;
		br(pisc_pkg::REG_RDDATA, v);
		check(v, {24'h0, exp});
	endtask
	task ack(input logic w, input logic [23:0] exp);
		bw(pisc_pkg::REG_CTRL, {30'h0, w, 1'b0});
		bw(pisc_pkg::REG_ACKCMD, 32'h0);
		idle;
		br(pisc_pkg::REG_VECTOR, v);
		check({8'h00, v[23:0]}, {8'h00, exp});
		br(pisc_pkg::REG_BUFEN, v);
		check({29'h0, v[3:1]}, 32'h0);
		check({31'h0, v[0]}, 32'h1);
	endtask
	task s_mask;
		dw(1'b1, 8'h5A);
		dr(1'b1, 8'h5A);
	endtask
	// Level 1 is masked yet still pending; level 2 wins the acknowledge.
	task s_status;
		irq <= 8'h26;
		repeat (4) @(posedge clk);
		dr(1'b0, 8'h26);
		ack(1'b0, 24'h020202);
		dr(1'b0, 8'h22);
		dw(1'b0, 8'h0B);
		dr(1'b0, 8'h04);
		dr(1'b0, 8'h04);
		dw(1'b0, 8'h0A);
		dr(1'b0, 8'h22);
		dw(1'b0, 8'h20);
		dw(1'b0, 8'h0B);
		dr(1'b0, 8'h00);
	endtask
	// A poll with the select bit set must still arm the poll; nothing unmasked is pending then.
	task s_poll;
		dw(1'b0, 8'h0E);
		br(pisc_pkg::REG_STATUS, v);
		check(v, 32'h2);
		dr(1'b0, 8'h85);
		br(pisc_pkg::REG_STATUS, v);
		check(v, 32'h0);
		dw(1'b0, 8'h0F);
		br(pisc_pkg::REG_STATUS, v);
		check(v, 32'h2);
		dr(1'b0, 8'h07);
		dr(1'b0, 8'h20);
	endtask
	// A real level 7 sets its in-service bit; a request dropped before the acknowledge does not.
	task s_default;
		@(posedge clk);
		irq <= 8'hA6;
		repeat (4) @(posedge clk);
		ack(1'b0, 24'h070707);
		dr(1'b0, 8'hA0);
		@(posedge clk);
		irq <= 8'hA7;
		repeat (4) @(posedge clk);
		irq <= 8'hA6;
		ack(1'b0, 24'h070707);
		dr(1'b0, 8'hA0);
		br(4'hF, v);
		check(v, 32'h0);
	endtask
	// Level mode: a held request comes back after its acknowledge until the source withdraws it.
	task s_level;
		dw(1'b0, 8'h1B);
		dr(1'b0, 8'hA6);
		ack(1'b0, 24'h020202);
		dr(1'b0, 8'hA6);
		@(posedge clk);
		irq <= 8'hA2;
		dr(1'b0, 8'hA2);
		ack(1'b1, 24'h000505);
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		s_mask;
		s_status;
		s_poll;
		s_default;
		s_level;
		end_sim;
	end
endmodule
